// [verification/btob_core_tb.sv]
`include "btob_regs.svh"

module bit_toggle_overflow_branch_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // design ports
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        srst_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        busy_o;
  logic [20:0] pc_o;
  int          mismatches;
  int          cmp_count;

  btob_core i_btob_core (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .busy_o            (busy_o),
    .pc_o              (pc_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // avalon access: hold until waitrequest sampled low
  // ----------------------------------------------------------------
  task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
           output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= addr;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    chk("bus answer", 32'h0000_0001, {31'h0, n < 50});
  endtask : bus

  task wr(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, addr, wd, dummy);
  endtask : wr

  task rd(input string what, input logic [7:0] addr, input logic [31:0] mask,
          input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, addr, 32'h0000_0000, v);
    chk(what, exp, v & mask);
  endtask : rd

  // start an operation, measure busy span in clocks, check cycle count
  task run(input logic [7:0] off, input logic [15:0] word, input int cyc,
           input logic span);
    int bsy;
    bsy = 0;
    wr(off, {16'h0000, word});
    repeat (80) begin
      @(posedge clk_i);
      if (busy_o === 1'b1) bsy++;
      else if (bsy > 0) break;
    end
    // the commit edge leaves one to four clocks of phase alignment
    if (span) chk("busy span", 32'h1, {31'h0, bsy >= 4 * cyc + 1 && bsy <= 4 * cyc + 4});
    rd("cycles", `BTOB_OFF_CYCLES, 32'h7, cyc);
  endtask : run

  task inv(input logic ext, input logic [3:0] bank, input logic [15:0] word,
           input logic [11:0] maddr, input logic [7:0] init,
           input logic [7:0] exp);
    wr(`BTOB_OFF_CTRL, {31'h0, ext});
    wr(`BTOB_OFF_BANK, {28'h0, bank});
    wr(`BTOB_OFF_INDEX, 32'h0000_0200);
    wr(`BTOB_OFF_MADDR, {20'h0, maddr});
    wr(`BTOB_OFF_MDATA, {24'h0, init});
    wr(`BTOB_OFF_PC, 32'h0000_0100);
    run(`BTOB_OFF_INSTR, word, 1, 1'b1);
    wr(`BTOB_OFF_MADDR, {20'h0, maddr});
    rd("inverted byte", `BTOB_OFF_MDATA, 32'hFF, {24'h0, exp});
    rd("pc after invert", `BTOB_OFF_PC, 32'h1F_FFFF, 32'h102);
  endtask : inv

  task branch_on_overflow_op(input logic ov, input logic [7:0] n, input logic [20:0] exp_pc);
    wr(`BTOB_OFF_STATUS, {31'h0, ov});
    wr(`BTOB_OFF_PC, 32'h0000_0100);
    run(`BTOB_OFF_INSTR, {8'hE4, n}, ov ? 2 : 1, 1'b1);
    rd("branch pc", `BTOB_OFF_PC, 32'h1F_FFFF, {11'h0, exp_pc});
    chk("pc port", {11'h0, exp_pc}, {11'h0, pc_o});
    rd("taken flag", `BTOB_OFF_STATUS, 32'h4, {29'h0, ov, 2'h0});
  endtask : branch_on_overflow_op

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("BAD watchdog expected done seen timeout");
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches       = 0;
    cmp_count        = 0;
    srst_i           = 1'b1;
    avs_address_i    = 8'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk("busy after reset", 32'h0, {31'h0, busy_o});
    chk("pc port after reset", 32'h0, {11'h0, pc_o});
    rd("pc reset", `BTOB_OFF_PC, 32'hFFFF_FFFF, 32'h0);
    rd("bank reset", `BTOB_OFF_BANK, 32'hFFFF_FFFF, 32'h0);
    rd("index reset", `BTOB_OFF_INDEX, 32'hFFFF_FFFF, 32'h0);
    rd("status reset", `BTOB_OFF_STATUS, 32'hF, 32'h0);
    rd("unmapped", 8'h30, 32'hFFFF_FFFF, 32'h0);
    // bit invert, each bank path and both sides of the 0x5F split
    inv(1'b0, 4'h0, 16'h7825, 12'h025, 8'h75, 8'h65);
    inv(1'b0, 4'h3, 16'h7110, 12'h310, 8'h00, 8'h01);
    inv(1'b0, 4'h3, 16'h7E80, 12'hF80, 8'h0F, 8'h8F);
    inv(1'b0, 4'h3, 16'h7E5F, 12'h05F, 8'h80, 8'h00);
    inv(1'b1, 4'h3, 16'h7405, 12'h205, 8'h00, 8'h04);
    inv(1'b1, 4'h3, 16'h7A5F, 12'h25F, 8'h00, 8'h20);
    inv(1'b1, 4'h3, 16'h7260, 12'hF60, 8'hFF, 8'hFD);
    // overflow branch, flag clear and set, offset extremes
    branch_on_overflow_op(1'b0, 8'h05, 21'h000102);
    branch_on_overflow_op(1'b1, 8'h05, 21'h00010C);
    branch_on_overflow_op(1'b1, 8'h80, 21'h000002);
    branch_on_overflow_op(1'b1, 8'h7F, 21'h000200);
    branch_on_overflow_op(1'b1, 8'hFF, 21'h000100);
    branch_on_overflow_op(1'b0, 8'h80, 21'h000102);
    // near miss of the branch opcode decodes as illegal
    wr(`BTOB_OFF_PC, 32'h0000_0100);
    run(`BTOB_OFF_INSTR, 16'hE000, 1, 1'b1);
    rd("illegal flag", `BTOB_OFF_STATUS, 32'h8, 32'h8);
    rd("illegal pc", `BTOB_OFF_PC, 32'h1F_FFFF, 32'h102);
    // skip over one- and two-word followers
    run(`BTOB_OFF_SKIP, 16'h0002, 3, 1'b0);
    rd("skip two pc", `BTOB_OFF_PC, 32'h1F_FFFF, 32'h108);
    run(`BTOB_OFF_SKIP, 16'h0000, 2, 1'b0);
    rd("skip one pc", `BTOB_OFF_PC, 32'h1F_FFFF, 32'h10C);
    // write during a taken branch is ignored
    wr(`BTOB_OFF_BANK, 32'h0000_0005);
    wr(`BTOB_OFF_STATUS, 32'h0000_0001);
    wr(`BTOB_OFF_INSTR, 32'h0000_E401);
    while (busy_o !== 1'b1) @(posedge clk_i);
    wr(`BTOB_OFF_BANK, 32'h0000_0009);
    rd("busy flag", `BTOB_OFF_STATUS, 32'h2, 32'h2);
    while (busy_o !== 1'b0) @(posedge clk_i);
    rd("bank kept", `BTOB_OFF_BANK, 32'hF, 32'h5);
    final_report();
  end

endmodule : bit_toggle_overflow_branch_exec_tb

// [verilog/btob_core.sv]
`include "btob_regs.svh"

module btob_core (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // core status
  output logic             busy_o,
  output logic [20:0]      pc_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]            dmem [0:4095];
  logic [1:0]            phase;
  logic                  req;
  logic                  commit_wr;
  logic [31:0]           rdata_nxt;
  logic                  wait_nxt;
  btob_pkg::btob_state_e state_r,   state_nxt;
  btob_pkg::btob_op_e    op_r,      op_nxt;
  btob_pkg::btob_op_e    op_dec;
  logic [15:0]           instr_r,   instr_nxt;
  logic [20:0]           pc_r,      pc_nxt;
  logic [3:0]            bank_r,    bank_nxt;
  logic [11:0]           index_r,   index_nxt;
  logic [11:0]           maddr_r,   maddr_nxt;
  logic [11:0]           addr_r,    addr_nxt;
  logic [11:0]           addr_dec;
  logic [7:0]            byte_r,    byte_nxt;
  logic [1:0]            nop_r,     nop_nxt;
  logic [2:0]            cyc_r,     cyc_nxt;
  logic [2:0]            last_r,    last_nxt;
  logic                  ext_r,     ext_nxt;
  logic                  ov_r,      ov_nxt;
  logic                  two_r,     two_nxt;
  logic                  taken_r,   taken_nxt;
  logic                  bad_r,     bad_nxt;
  logic                  mem_we;
  logic [7:0]            mem_wdata;
  logic [11:0]           mem_waddr;
  logic [7:0]            dmem_rd;
  logic [20:0]           bov_ofs;
  logic [31:0]           old_word;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction : be_merge

  btob_qseq u_qseq (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .phase_o (phase)
  );

  // ----------------------------------------------------------------
  // avalon slave: one wait state per access
  // ----------------------------------------------------------------
  assign req       = avs_read_i | avs_write_i;
  assign commit_wr = avs_write_i & ~avs_waitrequest_o;
  assign dmem_rd   = dmem[addr_r];

  always_comb begin
    wait_nxt  = ~(req & avs_waitrequest_o);
    rdata_nxt = 32'h00000000;
    unique case (avs_address_i)
      `BTOB_OFF_CTRL:   rdata_nxt = {31'h0, ext_r};
      `BTOB_OFF_INSTR:  rdata_nxt = {16'h0, instr_r};
      `BTOB_OFF_SKIP:   rdata_nxt = {30'h0, two_r, 1'b0};
      `BTOB_OFF_PC:     rdata_nxt = {11'h0, pc_r};
      `BTOB_OFF_BANK:   rdata_nxt = {28'h0, bank_r};
      `BTOB_OFF_INDEX:  rdata_nxt = {20'h0, index_r};
      `BTOB_OFF_STATUS: rdata_nxt = {28'h0, bad_r, taken_r, busy_o, ov_r};
      `BTOB_OFF_CYCLES: rdata_nxt = {29'h0, last_r};
      `BTOB_OFF_MADDR:  rdata_nxt = {20'h0, maddr_r};
      `BTOB_OFF_MDATA:  rdata_nxt = {24'h0, dmem[maddr_r]};
      default:          rdata_nxt = 32'h00000000;
    endcase
    if (!(avs_read_i & avs_waitrequest_o)) begin
      rdata_nxt = avs_readdata_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= wait_nxt;
      avs_readdata_o    <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // decode and address formation
  // ----------------------------------------------------------------
  assign bov_ofs = {{12{instr_r[7]}}, instr_r[7:0], 1'b0};

  always_comb begin
    if (instr_r[15:12] == `BTOB_OP_BITINV) begin
      op_dec = btob_pkg::OP_BITINV;
    end else if (instr_r[15:8] == `BTOB_OP_BOV) begin
      op_dec = btob_pkg::OP_BOV;
    end else begin
      op_dec = btob_pkg::OP_BAD;
    end
    if (instr_r[`BTOB_ACC_BIT]) begin
      addr_dec = {bank_r, instr_r[7:0]};
    end else if (ext_r && instr_r[7:0] <= `BTOB_ACC_LIMIT) begin
      addr_dec = index_r + {4'h0, instr_r[7:0]};
    end else if (instr_r[7:0] <= `BTOB_ACC_LIMIT) begin
      addr_dec = {`BTOB_ACC_LO_BANK, instr_r[7:0]};
    end else begin
      addr_dec = {`BTOB_ACC_HI_BANK, instr_r[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // execution sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    instr_nxt = instr_r;
    pc_nxt    = pc_r;
    bank_nxt  = bank_r;
    index_nxt = index_r;
    maddr_nxt = maddr_r;
    addr_nxt  = addr_r;
    byte_nxt  = byte_r;
    nop_nxt   = nop_r;
    cyc_nxt   = cyc_r;
    last_nxt  = last_r;
    ext_nxt   = ext_r;
    ov_nxt    = ov_r;
    two_nxt   = two_r;
    taken_nxt = taken_r;
    bad_nxt   = bad_r;
    mem_we    = 1'b0;
    mem_wdata = byte_r;
    mem_waddr = addr_r;
    old_word  = 32'h00000000;
    // bus writes are refused while an instruction runs
    if (commit_wr && state_r == btob_pkg::ST_IDLE) begin
      unique case (avs_address_i)
        `BTOB_OFF_CTRL: begin
          old_word = be_merge({31'h0, ext_r}, avs_writedata_i,
                              avs_byteenable_i);
          ext_nxt  = old_word[`BTOB_CTRL_EXT];
        end
        `BTOB_OFF_INSTR: begin
          old_word  = be_merge({16'h0, instr_r}, avs_writedata_i,
                               avs_byteenable_i);
          instr_nxt = old_word[15:0];
          op_nxt    = btob_pkg::OP_NONE;
          state_nxt = btob_pkg::ST_WAIT;
        end
        `BTOB_OFF_SKIP: begin
          old_word  = be_merge({30'h0, two_r, 1'b0}, avs_writedata_i,
                               avs_byteenable_i);
          two_nxt   = old_word[`BTOB_SKIP_TWO];
          op_nxt    = btob_pkg::OP_SKIP;
          state_nxt = btob_pkg::ST_WAIT;
        end
        `BTOB_OFF_PC: begin
          old_word = be_merge({11'h0, pc_r}, avs_writedata_i,
                              avs_byteenable_i);
          pc_nxt   = {old_word[20:1], 1'b0};
        end
        `BTOB_OFF_BANK: begin
          old_word = be_merge({28'h0, bank_r}, avs_writedata_i,
                              avs_byteenable_i);
          bank_nxt = old_word[3:0];
        end
        `BTOB_OFF_INDEX: begin
          old_word  = be_merge({20'h0, index_r}, avs_writedata_i,
                               avs_byteenable_i);
          index_nxt = old_word[11:0];
        end
        `BTOB_OFF_STATUS: begin
          old_word = be_merge({31'h0, ov_r}, avs_writedata_i,
                              avs_byteenable_i);
          ov_nxt   = old_word[`BTOB_ST_OV];
        end
        `BTOB_OFF_MADDR: begin
          old_word  = be_merge({20'h0, maddr_r}, avs_writedata_i,
                               avs_byteenable_i);
          maddr_nxt = old_word[11:0];
        end
        `BTOB_OFF_MDATA: begin
          mem_we    = avs_byteenable_i[0];
          mem_waddr = maddr_r;
          mem_wdata = avs_writedata_i[7:0];
        end
        default: begin
          old_word = 32'h00000000;
        end
      endcase
    end
    unique case (state_r)
      btob_pkg::ST_IDLE: begin
        cyc_nxt = 3'h0;
      end
      btob_pkg::ST_WAIT: begin
        // start on a cycle boundary so phases line up with Q1..Q4
        if (phase == `BTOB_PH_Q4) begin
          state_nxt = btob_pkg::ST_EXEC;
        end
      end
      btob_pkg::ST_EXEC: begin
        unique case (phase)
          `BTOB_PH_Q1: begin
            pc_nxt    = pc_r + `BTOB_PC_STEP;
            taken_nxt = 1'b0;
            bad_nxt   = 1'b0;
            addr_nxt  = addr_dec;
            if (op_r != btob_pkg::OP_SKIP) begin
              op_nxt  = op_dec;
              bad_nxt = (op_dec == btob_pkg::OP_BAD);
            end
          end
          `BTOB_PH_Q2: begin
            byte_nxt = dmem_rd;
          end
          `BTOB_PH_Q3: begin
            if (op_r == btob_pkg::OP_BITINV) begin
              byte_nxt = byte_r ^ (8'h01 << instr_r[11:9]);
            end
            if (op_r == btob_pkg::OP_BOV) begin
              taken_nxt = ov_r;
            end
          end
          `BTOB_PH_Q4: begin
            cyc_nxt = cyc_r + 3'h1;
            nop_nxt = 2'h0;
            if (op_r == btob_pkg::OP_BITINV) begin
              mem_we = 1'b1;
            end
            if (op_r == btob_pkg::OP_BOV && taken_r) begin
              pc_nxt  = pc_r + bov_ofs;
              nop_nxt = `BTOB_NOP_TAKEN;
            end
            if (op_r == btob_pkg::OP_SKIP) begin
              nop_nxt = two_r ? `BTOB_NOP_SKIP2
                              : `BTOB_NOP_SKIP1;
            end
            if (nop_nxt == 2'h0) begin
              state_nxt = btob_pkg::ST_IDLE;
              last_nxt  = cyc_r + 3'h1;
            end else begin
              state_nxt = btob_pkg::ST_NOP;
            end
          end
        endcase
      end
      btob_pkg::ST_NOP: begin
        // a skipped word is stepped over without being executed
        if (phase == `BTOB_PH_Q1 && op_r == btob_pkg::OP_SKIP) begin
          pc_nxt = pc_r + `BTOB_PC_STEP;
        end
        if (phase == `BTOB_PH_Q4) begin
          cyc_nxt = cyc_r + 3'h1;
          nop_nxt = nop_r - 2'h1;
          if (nop_r == 2'h1) begin
            state_nxt = btob_pkg::ST_IDLE;
            last_nxt  = cyc_r + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      dmem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= btob_pkg::ST_IDLE;
      op_r    <= btob_pkg::OP_NONE;
      instr_r <= `BTOB_INSTR_RST;
      pc_r    <= `BTOB_PC_RST;
      bank_r  <= `BTOB_BANK_RST;
      index_r <= `BTOB_INDEX_RST;
      maddr_r <= 12'h000;
      addr_r  <= 12'h000;
      byte_r  <= 8'h00;
      nop_r   <= 2'h0;
      cyc_r   <= 3'h0;
      last_r  <= 3'h0;
      ext_r   <= 1'b0;
      ov_r    <= 1'b0;
      two_r   <= 1'b0;
      taken_r <= 1'b0;
      bad_r   <= 1'b0;
      busy_o  <= 1'b0;
      pc_o    <= `BTOB_PC_RST;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      instr_r <= instr_nxt;
      pc_r    <= pc_nxt;
      bank_r  <= bank_nxt;
      index_r <= index_nxt;
      maddr_r <= maddr_nxt;
      addr_r  <= addr_nxt;
      byte_r  <= byte_nxt;
      nop_r   <= nop_nxt;
      cyc_r   <= cyc_nxt;
      last_r  <= last_nxt;
      ext_r   <= ext_nxt;
      ov_r    <= ov_nxt;
      two_r   <= two_nxt;
      taken_r <= taken_nxt;
      bad_r   <= bad_nxt;
      busy_o  <= (state_nxt != btob_pkg::ST_IDLE);
      pc_o    <= pc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_q1(btob_pkg::btob_op_e o);
    state_r == btob_pkg::ST_EXEC && phase == `BTOB_PH_Q1 && op_dec == o
      && op_r != btob_pkg::OP_SKIP;
  endsequence
  sequence s_bov_taken;
    s_q1(btob_pkg::OP_BOV) ##0 ov_r;
  endsequence
  sequence s_bov_fall;
    s_q1(btob_pkg::OP_BOV) ##0 !ov_r;
  endsequence

  chk_invert_write: assert property (
    state_r == btob_pkg::ST_EXEC && phase == `BTOB_PH_Q2
      && op_r == btob_pkg::OP_BITINV
    |-> ##2 (mem_we && mem_waddr == $past(addr_r, 2) && mem_wdata ==
             ($past(dmem_rd, 2) ^ (8'h01 << instr_r[11:9]))))
    else $error("bit invert wrote wrong byte");
  chk_bank_addr: assert property (
    s_q1(btob_pkg::OP_BITINV) ##0 instr_r[`BTOB_ACC_BIT]
    |=> addr_r == {bank_r, instr_r[7:0]})
    else $error("banked address wrong");
  chk_indexed_addr: assert property (
    s_q1(btob_pkg::OP_BITINV) ##0 (!instr_r[`BTOB_ACC_BIT] && ext_r
      && instr_r[7:0] <= `BTOB_ACC_LIMIT)
    |=> addr_r == index_r + {4'h0, instr_r[7:0]})
    else $error("indexed address wrong");
  chk_bov_decode: assert property (
    state_r == btob_pkg::ST_EXEC && phase == `BTOB_PH_Q1
      && op_r != btob_pkg::OP_SKIP && instr_r[15:8] == `BTOB_OP_BOV
    |=> op_r == btob_pkg::OP_BOV && !bad_r)
    else $error("overflow branch not decoded");
  chk_no_jump_pc: assert property (
    s_bov_fall |-> ##4 (pc_r == $past(pc_r, 4) + `BTOB_PC_STEP
                        && state_r == btob_pkg::ST_IDLE))
    else $error("untaken branch moved pc");
  chk_jump_target: assert property (
    s_bov_taken |-> ##4 pc_r == $past(pc_r, 4) + `BTOB_PC_STEP + bov_ofs)
    else $error("branch target wrong");
  chk_taken_cycles: assert property (
    s_bov_taken |-> ##4 (state_r == btob_pkg::ST_NOP)[*4]
                    ##1 (state_r == btob_pkg::ST_IDLE && last_r == 3'h2))
    else $error("taken branch cycle count wrong");
  chk_skip_two: assert property (
    state_r == btob_pkg::ST_EXEC && phase == `BTOB_PH_Q1
      && op_r == btob_pkg::OP_SKIP && two_r
    |-> ##4 (state_r == btob_pkg::ST_NOP)[*8]
        ##1 (state_r == btob_pkg::ST_IDLE && last_r == 3'h3))
    else $error("two-word skip timing wrong");

endmodule : btob_core

// [verilog/btob_pkg.sv]
package btob_pkg;

  // ----------------------------------------------------------------
  // sequencer states and decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXEC,
    ST_NOP
  } btob_state_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_BITINV,
    OP_BOV,
    OP_SKIP,
    OP_BAD
  } btob_op_e;

endpackage : btob_pkg

// [verilog/btob_qseq.sv]
`include "btob_regs.svh"

// free-running four-phase counter, one clock per phase
module btob_qseq (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // phase index
  output logic [1:0]      phase_o
);

  logic [1:0] phase_nxt;

  always_comb begin
    phase_nxt = phase_o + 2'h1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_o <= `BTOB_PH_Q1;
    end else begin
      phase_o <= phase_nxt;
    end
  end

endmodule : btob_qseq

// [verilog/btob_regs.svh]
`ifndef BTOB_REGS_SVH
`define BTOB_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BTOB_OFF_CTRL     8'h00
`define BTOB_OFF_INSTR    8'h04
`define BTOB_OFF_SKIP     8'h08
`define BTOB_OFF_PC       8'h0C
`define BTOB_OFF_BANK     8'h10
`define BTOB_OFF_INDEX    8'h14
`define BTOB_OFF_STATUS   8'h18
`define BTOB_OFF_CYCLES   8'h1C
`define BTOB_OFF_MADDR    8'h20
`define BTOB_OFF_MDATA    8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BTOB_CTRL_EXT     0
`define BTOB_SKIP_TWO     1
`define BTOB_ST_OV        0
`define BTOB_ST_BUSY      1
`define BTOB_ST_TAKEN     2
`define BTOB_ST_BAD       3
`define BTOB_ACC_BIT      8

// ----------------------------------------------------------------
// opcodes and address constants
// ----------------------------------------------------------------
`define BTOB_OP_BITINV    4'h7
`define BTOB_OP_BOV       8'hE4
`define BTOB_ACC_LIMIT    8'h5F
`define BTOB_ACC_HI_BANK  4'hF
`define BTOB_ACC_LO_BANK  4'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BTOB_PC_RST       21'h000000
`define BTOB_BANK_RST     4'h0
`define BTOB_INDEX_RST    12'h000
`define BTOB_INSTR_RST    16'h0000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define BTOB_PC_STEP      21'h000002
`define BTOB_PH_Q1        2'h0
`define BTOB_PH_Q2        2'h1
`define BTOB_PH_Q3        2'h2
`define BTOB_PH_Q4        2'h3
`define BTOB_NOP_TAKEN    2'h1
`define BTOB_NOP_SKIP1    2'h1
`define BTOB_NOP_SKIP2    2'h2

`endif
